// *** verilog/ppm_map.vh ***
// Behaviour
// - Power control/status survives the internal reset on D3hot to D0.
// - Wake-event flag bit 15 sets on every wake event, whatever the enable.
// - Writing 1 clears the wake-event flag and drops wake output; 0 ignored.
// - Data-scaling bits 14-13 and data-choice bits 12-9 always read zero.
// - Wake output asserts only while wake-assert enable bit 8 is one.
// - Without D3cold wake, enable resets to 0; with it, enable is sticky.
// - Reserved bits 7-2 of power control/status always read zero.
// - Power-state field bits 1-0 select D0, D1, D2 or D3.
// - Power extension register at 4Ah is read-only and reads all zero.
// - Routing bit 7 set sends cable-inactive indication to its output.
// - With EEPROM present, routing bit loads from bit 7 of byte 16h.
// - Read-only bit 3 of PHY output control resets to one.
// - Bits 31-8 of PHY output control always read zero.
`ifndef PPM_MAP_VH
`define PPM_MAP_VH

`define PPM_OFS_POWER_CTRL_STATUS 8'h48
`define PPM_OFS_POWER_EXTENSION   8'h4A
`define PPM_OFS_PHY_OUTPUT_CTRL   8'hEC

`define PPM_BIT_WAKE_FLAG         15
`define PPM_BIT_WAKE_ENABLE       8
`define PPM_BIT_ROUTE_ENABLE      7
`define PPM_BIT_COMPLIANCE        3

`define PPM_RST_POWER_CTRL_STATUS 16'h0000
`define PPM_RST_POWER_EXTENSION   16'h0000
`define PPM_RST_PHY_OUTPUT_CTRL   32'h00000008
`define PPM_RST_PHY_LOW           7'h08
`define PPM_RST_WAKE_FLAG         1'b0

`define PPM_STATE_D0              2'h0
`define PPM_STATE_D1              2'h1
`define PPM_STATE_D2              2'h2
`define PPM_STATE_D3              2'h3

`endif

// *** verilog/ppm_sync.v ***
`timescale 1ns/1ps
module ppm_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);
    reg [WIDTH-1:0] stage;

    // stage feeds q only; nothing else may look at it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= {WIDTH{1'b0}};
            q     <= {WIDTH{1'b0}};
        end else begin
            stage <= d;
            q     <= stage;
        end
    end
endmodule // ppm_sync

// *** verilog/ppm_regs.v ***
`timescale 1ns/1ps
`include "ppm_map.vh"
module ppm_regs (
    input  wire        REF_CLK,
    input  wire        NRST,
    input  wire        AUX_NRST,
    input  wire        CFG_REQ,
    input  wire        CFG_WR,
    input  wire [5:0]  CFG_DWORD,
    input  wire [3:0]  CFG_BE,
    input  wire [31:0] CFG_WDATA,
    output reg         CFG_ACK,
    output reg  [31:0] CFG_RDATA,
    input  wire        WAKE_EVENT,
    input  wire        EE_LOAD,
    input  wire [7:0]  EE_BYTE,
    input  wire        CNA_IN,
    input  wire        D3COLD_STRAP,
    output reg         PME_O,
    output reg         PME_OE_N,
    output reg         CNA_OUT,
    output reg  [1:0]  POWER_STATE,
    output reg         FUNC_RESET
);
    // main and aux-well resets, both released through two flops
    wire rst_n;
    wire aux_rst_n;
    wire cna_sync;
    wire d3cold_sync;

    ppm_sync #(.WIDTH(1)) u_rst_sync (
        .clk   (REF_CLK),
        .rst_n (NRST),
        .d     (1'b1),
        .q     (rst_n)
    );

    ppm_sync #(.WIDTH(1)) u_aux_sync (
        .clk   (REF_CLK),
        .rst_n (AUX_NRST),
        .d     (1'b1),
        .q     (aux_rst_n)
    );

    // pins from outside the clock domain
    ppm_sync #(.WIDTH(2)) u_pin_sync (
        .clk   (REF_CLK),
        .rst_n (aux_rst_n),
        .d     ({D3COLD_STRAP, CNA_IN}),
        .q     ({d3cold_sync, cna_sync})
    );

    function hit;
        input [5:0] dword;
        input [7:0] offset;
        begin
            hit = (dword == offset[7:2]);
        end
    endfunction

    wire wr_req = CFG_REQ & CFG_WR;
    wire rd_req = CFG_REQ & ~CFG_WR;
    wire wr_pm  = wr_req & hit(CFG_DWORD, `PPM_OFS_POWER_CTRL_STATUS);
    wire wr_phy = wr_req & hit(CFG_DWORD, `PPM_OFS_PHY_OUTPUT_CTRL);

    // stored state; everything else in these registers is constant zero
    reg       wake_event_flag;
    reg       wake_assert_enable;
    reg [1:0] power_state_field;
    reg       cable_activity_route_enable;
    reg [6:0] phy_low;

    reg       next_flag;
    reg       next_enable;
    reg [1:0] next_state;

    always @* begin
        next_flag   = wake_event_flag;
        next_enable = wake_assert_enable;
        next_state  = power_state_field;
        if (wr_pm && CFG_BE[1] && CFG_WDATA[`PPM_BIT_WAKE_FLAG]) begin
            next_flag = 1'b0;
        end
        if (WAKE_EVENT) begin
            // set beats a clear landing in the same cycle
            next_flag = 1'b1;
        end
        if (wr_pm && CFG_BE[1]) begin
            next_enable = CFG_WDATA[`PPM_BIT_WAKE_ENABLE];
        end
        if (wr_pm && CFG_BE[0]) begin
            next_state = CFG_WDATA[1:0];
        end
    end

    // only a main reset touches this; the D3hot exit pulse does not
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wake_event_flag   <= `PPM_RST_WAKE_FLAG;
            power_state_field <= `PPM_STATE_D0;
        end else begin
            wake_event_flag   <= next_flag;
            power_state_field <= next_state;
        end
    end

    // enable lives in the aux well so it can outlast a main reset
    always @(posedge REF_CLK or negedge aux_rst_n) begin
        if (!aux_rst_n) begin
            wake_assert_enable <= 1'b0;
        end else if (!rst_n && !d3cold_sync) begin
            wake_assert_enable <= 1'b0;
        end else if (rst_n) begin
            wake_assert_enable <= next_enable;
        end
    end

    // phy output control: only bit 7 is software-writable
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cable_activity_route_enable <= 1'b0;
            phy_low <= `PPM_RST_PHY_LOW;
        end else if (EE_LOAD) begin
            // image must keep bit 3 set and the rest zero
            cable_activity_route_enable <= EE_BYTE[7];
            phy_low <= EE_BYTE[6:0];
        end else if (wr_phy && CFG_BE[0]) begin
            // other lanes and bits 6-0 are dropped
            cable_activity_route_enable <= CFG_WDATA[7];
        end
    end

    wire [15:0] pm_word = {wake_event_flag,
                           4'h0, 2'h0,
                           wake_assert_enable,
                           6'h00,
                           power_state_field};
    wire [15:0] ext_word = `PPM_RST_POWER_EXTENSION;
    wire [31:0] phy_word = {24'h000000,
                            cable_activity_route_enable,
                            phy_low};

    reg [31:0] next_rdata;

    always @* begin
        next_rdata = 32'h00000000;
        if (hit(CFG_DWORD, `PPM_OFS_POWER_CTRL_STATUS)) begin
            next_rdata = {ext_word, pm_word};
        end else if (hit(CFG_DWORD, `PPM_OFS_PHY_OUTPUT_CTRL)) begin
            next_rdata = phy_word;
        end
    end

    wire d3_exit = wr_pm && CFG_BE[0]
                   && power_state_field == `PPM_STATE_D3
                   && CFG_WDATA[1:0] == `PPM_STATE_D0;

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            CFG_ACK     <= 1'b0;
            CFG_RDATA   <= 32'h00000000;
            PME_O       <= 1'b0;
            PME_OE_N    <= 1'b1;
            CNA_OUT     <= 1'b0;
            POWER_STATE <= `PPM_STATE_D0;
            FUNC_RESET  <= 1'b0;
        end else begin
            CFG_ACK     <= CFG_REQ;
            CFG_RDATA   <= rd_req ? next_rdata : 32'h00000000;
            PME_O       <= 1'b0;
            // open drain: pulled low only while flag and enable are both set
            PME_OE_N    <= ~(next_flag & next_enable);
            CNA_OUT     <= cable_activity_route_enable
                           & cna_sync;
            POWER_STATE <= next_state;
            FUNC_RESET  <= d3_exit;
        end
    end
endmodule // ppm_regs

// *** test/ppm_regs_properties.sv ***
`timescale 1ns/1ps
module ppm_regs_properties (
    input wire logic        REF_CLK, NRST, CFG_REQ, CFG_WR, CFG_ACK,
    input wire logic        WAKE_EVENT, CNA_IN, PME_O, PME_OE_N,
    input wire logic        CNA_OUT, FUNC_RESET,
    input wire logic [5:0]  CFG_DWORD,
    input wire logic [3:0]  CFG_BE,
    input wire logic [31:0] CFG_WDATA, CFG_RDATA,
    input wire logic [1:0]  POWER_STATE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    wire wr12 = CFG_REQ && CFG_WR && CFG_DWORD == 6'h12;
    wire rd = CFG_REQ && !CFG_WR;
    AST_ACK: assert property (CFG_REQ |=> CFG_ACK) else $error("no ack");
    AST_PME_LOW: assert property (!PME_O) else $error("pme data");
    AST_PME_SRC:
        assert property ($fell(PME_OE_N) |-> $past(WAKE_EVENT || wr12))
        else $error("pme without cause");
    AST_PME_CLR:
        assert property (wr12 && CFG_BE[1] && CFG_WDATA[15] && !WAKE_EVENT
            |=> PME_OE_N) else $error("pme not cleared");
    AST_PSTATE:
        assert property (wr12 && CFG_BE[0] |=>
            POWER_STATE == $past(CFG_WDATA[1:0])) else $error("pstate");
    AST_FRST:
        assert property (FUNC_RESET |-> ##[0:1] POWER_STATE == 2'h0)
        else $error("func reset state");
    AST_RD_IDLE: assert property (!rd |=> CFG_RDATA == 32'h0)
        else $error("rdata not idle");
    AST_RD_PM:
        assert property (rd && CFG_DWORD == 6'h12 |=> CFG_RDATA[31:16] == 16'h0
            && CFG_RDATA[14:9] == 6'h0 && CFG_RDATA[7:2] == 6'h0)
        else $error("pm zero bits");
    AST_RD_PHY:
        assert property (rd && CFG_DWORD == 6'h3B |=> CFG_RDATA[31:8] == 24'h0)
        else $error("phy zero bits");
    AST_CNA: assert property (CNA_OUT |-> $past(CNA_IN, 3))
        else $error("cna out");
    CV_WAKE: cover property ($fell(PME_OE_N));
    CV_FRST: cover property (FUNC_RESET);
    CV_CNA: cover property ($rose(CNA_OUT));
endmodule // ppm_regs_properties
bind ppm_regs ppm_regs_properties ppm_regs_properties_i (.REF_CLK, .NRST,
    .CFG_REQ, .CFG_WR, .CFG_ACK, .WAKE_EVENT, .CNA_IN, .PME_O, .PME_OE_N,
    .CNA_OUT, .FUNC_RESET, .CFG_DWORD, .CFG_BE, .CFG_WDATA, .CFG_RDATA,
    .POWER_STATE);

// *** test/ppm_host.sv ***
`timescale 1ns/1ps
module ppm_host (
    input  wire logic        clk,
    output logic             req, wr, ee_load,
    output logic [5:0]       dword,
    output logic [3:0]       be,
    output logic [31:0]      wdata,
    output logic [7:0]       ee_byte,
    input  wire logic        ack,
    input  wire logic [31:0] rdata
);
    assign ee_byte = 8'h88;
    initial {req, wr, ee_load, dword, be, wdata} = '0;
    task automatic acc(input logic w, input logic [5:0] d,
        input logic [3:0] b, input logic [31:0] v,
        output logic [31:0] q, output logic a);
        @(posedge clk); #5;
        req = 1'b1; wr = w; dword = d; be = b; wdata = v;
        @(posedge clk); #5;
        req = 1'b0;
        wdata = ~v; // stale data would hide a missing request qualifier
        a = ack;
        q = rdata;
    endtask
    task automatic ee();
        @(posedge clk); #5 ee_load = 1'b1;
        @(posedge clk); #5 ee_load = 1'b0;
    endtask
endmodule // ppm_host

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic REF_CLK = 0, NRST = 0, AUX_NRST = 0, WAKE_EVENT = 0, CNA_IN = 0;
    logic D3COLD_STRAP = 1, CFG_REQ, CFG_WR, CFG_ACK, EE_LOAD, PME_O;
    logic PME_OE_N, CNA_OUT, FUNC_RESET, a;
    logic [5:0] CFG_DWORD;
    logic [3:0] CFG_BE;
    logic [31:0] CFG_WDATA, CFG_RDATA, q;
    logic [7:0] EE_BYTE;
    logic [1:0] POWER_STATE;
    int bad_count = 0, total_checks = 0;
    ppm_regs ppm_regs_i (.REF_CLK, .NRST, .AUX_NRST, .CFG_REQ, .CFG_WR,
        .CFG_DWORD, .CFG_BE, .CFG_WDATA, .CFG_ACK, .CFG_RDATA, .WAKE_EVENT,
        .EE_LOAD, .EE_BYTE, .CNA_IN, .D3COLD_STRAP, .PME_O, .PME_OE_N,
        .CNA_OUT, .POWER_STATE, .FUNC_RESET);
    ppm_host ppm_host_i (.clk(REF_CLK), .req(CFG_REQ), .wr(CFG_WR),
        .ee_load(EE_LOAD), .dword(CFG_DWORD), .be(CFG_BE), .wdata(CFG_WDATA),
        .ee_byte(EE_BYTE), .ack(CFG_ACK), .rdata(CFG_RDATA));
    initial forever #50 REF_CLK = ~REF_CLK;
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
        #5;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [5:0] d, input logic [31:0] e);
        ppm_host_i.acc(1'b0, d, 4'h0, 32'h0, q, a);
        chk({31'h0, a}, 32'h1);
        chk(q, e);
    endtask
    task automatic wr(input logic [5:0] d, input logic [3:0] b,
        input logic [31:0] v);
        ppm_host_i.acc(1'b1, d, b, v, q, a);
        chk(q, 32'h0);
    endtask
    task automatic rst();
        cyc(1);
        NRST = 0;
        cyc(10);
        NRST = 1;
        AUX_NRST = 1;
        cyc(3);
    endtask
    task automatic wake();
        cyc(1);
        WAKE_EVENT = 1;
        cyc(1);
        WAKE_EVENT = 0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
    initial begin
        rst();
        rd(6'h12, 32'h0);
        rd(6'h3B, 32'h8);
        rd(6'h00, 32'h0);
        wr(6'h12, 4'hF, 32'hFFFFFFFF);
        rd(6'h12, 32'h103);
        wake();
        chk({31'h0, PME_OE_N}, 32'h0);
        rd(6'h12, 32'h8103);
        wr(6'h12, 4'h2, 32'h100);
        rd(6'h12, 32'h8103);
        wr(6'h12, 4'h2, 32'h8100);
        chk({31'h0, PME_OE_N}, 32'h1);
        wr(6'h12, 4'h2, 32'h0);
        wake();
        chk({31'h0, PME_OE_N}, 32'h1);
        rd(6'h12, 32'h8003);
        wr(6'h12, 4'h1, 32'h0);
        chk({31'h0, FUNC_RESET}, 32'h1);
        chk({31'h0, PME_O}, 32'h0);
        rd(6'h12, 32'h8000);
        wr(6'h12, 4'h2, 32'h8100);
        for (int i = 0; i < 4; i++) begin
            wr(6'h12, 4'h1, i);
            cyc(1);
            chk({30'h0, POWER_STATE}, i);
        end
        $display("power control test done");
        rst();
        rd(6'h12, 32'h100);
        D3COLD_STRAP = 0;
        rst();
        rd(6'h12, 32'h0);
        $display("sticky enable test done");
        ppm_host_i.ee();
        rd(6'h3B, 32'h88);
        CNA_IN = 1;
        cyc(4);
        chk({31'h0, CNA_OUT}, 32'h1);
        wr(6'h3B, 4'hF, 32'hFFFFFFFF);
        rd(6'h3B, 32'h88);
        wr(6'h3B, 4'h1, 32'h0);
        cyc(1);
        chk({31'h0, CNA_OUT}, 32'h0);
        rd(6'h3B, 32'h8);
        $display("phy control test done");
        print_verdict();
    end
endmodule // tb_top
